// >>> pss_debounce.sv
// Debounce filter: output follows input after a stable run
`timescale 1ns/100ps
module pss_debounce #(
   parameter int unsigned STABLE_CYC = 45
) (
   input  wire logic   clock,
   input  wire logic   rst_n,
   pss_filt_if.filter  port_f
);
   logic [7:0] count;
   logic [7:0] next_count;
   logic       next_clean;
   logic       clean_q;

   assign port_f.clean = clean_q;

   always_comb begin
      next_count = 8'h00;
      next_clean = clean_q;
      if (port_f.raw != clean_q) begin
         next_count = count + 8'h01;
         if (count == 8'(STABLE_CYC - 1)) begin
            next_clean = port_f.raw;
            next_count = 8'h00;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count   <= 8'h00;
         clean_q <= 1'b0;
      end else begin
         count   <= next_count;
         clean_q <= next_clean;
      end
   end

   // Glitch shorter than the window never moves the output
   short_glitch_a: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(clean_q) |-> $past(port_f.raw, 1) == clean_q)
      else $error("debounce output moved without a stable input");
endmodule : pss_debounce

// >>> pss_if.sv
// Interface between the sequencer and its debounce filter
`timescale 1ns/100ps
interface pss_filt_if;
   logic raw;
   logic clean;
   modport owner (output raw, input clean);
   modport filter (input raw, output clean);
endinterface : pss_filt_if

// >>> pss_pkg.sv
// Package of timing constants and enumerations for the switch sequencer
package pss_pkg;
   localparam int unsigned CLOCK_HZ = 25000000;
   localparam int unsigned TIMER_W = 32;
   // Target period of the A option, 65 kHz
   localparam int unsigned TARGET_PERIOD_NS = 15385;
   localparam int unsigned TARGET_PERIOD_CYC = TARGET_PERIOD_NS * 25 / 1000;
   localparam int unsigned STARTUP_TIMEOUT_MS = 100;
   localparam int unsigned STARTUP_TIMEOUT_CYC = STARTUP_TIMEOUT_MS * (CLOCK_HZ / 1000);
   localparam int unsigned LINE_LOSS_MS = 64;
   localparam int unsigned LINE_LOSS_CYC = LINE_LOSS_MS * (CLOCK_HZ / 1000);
   localparam int unsigned SOFT_START_MS = 130;
   localparam int unsigned SOFT_START_CYC = SOFT_START_MS * (CLOCK_HZ / 1000);
   // Debounce is a least time, rounded up
   localparam int unsigned IDLE_DEBOUNCE_NS = 1800;
   localparam int unsigned IDLE_DEBOUNCE_CYC = (IDLE_DEBOUNCE_NS * 25 + 999) / 1000;
   localparam int unsigned RAMP_W = 8;
   localparam logic [7:0] RAMP_FULL = 8'hFF;

   typedef enum logic [4:0] {
      PSS_OFF     = 5'h01,
      PSS_CHARGE  = 5'h02,
      PSS_ON_TIME = 5'h04,
      PSS_OFF_TIME= 5'h08,
      PSS_PAUSE   = 5'h10
   } pss_phase_e;
endpackage : pss_pkg

// >>> pss_sequencer.sv
// Switch sequencer top: gate timing, startup supply, line discharge, soft-start, burst and idle
`timescale 1ns/100ps
module pss_sequencer #(
   parameter int unsigned STARTUP_TIMEOUT_CYC = pss_pkg::STARTUP_TIMEOUT_CYC,
   parameter int unsigned LINE_LOSS_CYC       = pss_pkg::LINE_LOSS_CYC,
   parameter int unsigned SOFT_START_CYC      = pss_pkg::SOFT_START_CYC
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             current_ref_reached,
   input  wire logic             peak_limit_comparator,
   input  wire logic             line_above_start,
   input  wire logic             line_above_safe,
   input  wire logic             line_loss_detected,
   input  wire logic             supply_above_short,
   input  wire logic             supply_at_turn_on,
   input  wire logic             supply_at_turn_off,
   input  wire logic             supply_near_turn_off,
   input  wire logic             feedback_above_release,
   input  wire logic             feedback_below_idle,
   input  wire logic             feedback_above_idle_exit,
   input  wire logic             feedback_at_reference,
   input  wire logic             comp_below_burst_stop,
   input  wire logic             comp_above_burst_restart,
   output logic                  gate_drive_out,
   output logic                  startup_source_on,
   output logic                  startup_source_reduced,
   output logic                  discharge_on,
   output logic [7:0]            peak_limit_level,
   output logic                  external_idle_mode,
   output logic                  error_amp_on,
   output logic                  comp_high_z,
   output logic                  feedback_pullup_weak,
   output logic                  feedback_pullup_strong,
   output logic                  low_power
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int unsigned NIN = 15;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] sync_a;
   logic [NIN-1:0] sync_b;
   assign raw_in = {current_ref_reached, peak_limit_comparator, line_above_start, line_above_safe,
                    line_loss_detected, supply_above_short, supply_at_turn_on, supply_at_turn_off,
                    supply_near_turn_off, feedback_above_release, feedback_below_idle,
                    feedback_above_idle_exit, feedback_at_reference, comp_below_burst_stop,
                    comp_above_burst_restart};

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_sync
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   logic s_ref, s_ocp, s_lstart, s_lsafe, s_lloss, s_vshort, s_von, s_voff, s_vnear;
   logic s_fbrel, s_fbidle, s_fbexit, s_fbref, s_cstop, s_crest;
   assign {s_ref, s_ocp, s_lstart, s_lsafe, s_lloss, s_vshort, s_von, s_voff, s_vnear,
           s_fbrel, s_fbidle, s_fbexit, s_fbref, s_cstop, s_crest} = sync_b;

   // ------------------------------------------------------------
   // Idle debounce
   // ------------------------------------------------------------
   logic        idle_state;
   pss_filt_if idle_f ();
   assign idle_f.raw = idle_state ? !s_fbexit : s_fbidle;
   pss_debounce #(.STABLE_CYC(pss_pkg::IDLE_DEBOUNCE_CYC)) u_idle_db (
      .clock (clock),
      .rst_n (rst_n),
      .port_f(idle_f)
   );

   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------
   pss_pkg::pss_phase_e phase, next_phase;
   logic [31:0] on_cnt, next_on_cnt;
   logic [31:0] off_cnt, next_off_cnt;
   logic [31:0] off_limit, next_off_limit;
   logic [31:0] tout_cnt, next_tout_cnt;
   logic [31:0] loss_cnt, next_loss_cnt;
   logic [31:0] ss_cnt, next_ss_cnt;
   logic        burst, next_burst;
   logic        next_idle_state;
   logic        boost_pull, next_boost_pull;
   logic        hv_run, next_hv_run;
   logic        recharge, next_recharge;
   logic        disch, next_disch;
   logic        ss_done;
   logic        running;

   assign running = (phase == pss_pkg::PSS_ON_TIME) || (phase == pss_pkg::PSS_OFF_TIME)
                    || (phase == pss_pkg::PSS_PAUSE);
   assign ss_done = (ss_cnt >= SOFT_START_CYC);

   always_comb begin
      next_phase      = phase;
      next_on_cnt     = on_cnt;
      next_off_cnt    = off_cnt;
      next_off_limit  = off_limit;
      next_tout_cnt   = tout_cnt;
      next_loss_cnt   = 32'h00000000;
      next_ss_cnt     = ss_cnt;
      next_burst      = burst;
      next_idle_state = idle_state;
      next_boost_pull = boost_pull;
      next_hv_run     = hv_run;
      next_recharge   = recharge;
      next_disch      = disch;

      if (s_lloss && !disch) begin
         next_loss_cnt = loss_cnt + 32'h00000001;
         if (loss_cnt >= LINE_LOSS_CYC - 1) begin
            next_disch = 1'b1;
         end
      end
      if (disch && !s_lsafe) begin
         next_disch = 1'b0;
      end

      if (running && !ss_done) begin
         next_ss_cnt = ss_cnt + 32'h00000001;
      end

      if (running && hv_run) begin
         next_tout_cnt = tout_cnt + 32'h00000001;
         if (s_fbrel) begin
            next_hv_run = 1'b0;
         end
         if (tout_cnt >= STARTUP_TIMEOUT_CYC - 1) begin
            next_hv_run = 1'b0;
         end
      end

      // idle recharge between levels, set wins over clear
      if (recharge && s_von) begin
         next_recharge = 1'b0;
      end
      if (idle_state && s_vnear) begin
         next_recharge = 1'b1;
      end

      if (running && !idle_state && idle_f.clean) begin
         next_idle_state = 1'b1;
         next_boost_pull = 1'b0;
      end
      if (boost_pull && s_fbref) begin
         next_boost_pull = 1'b0;
      end
      // strong pull-up after exit threshold, set wins
      if (idle_state && s_fbexit) begin
         next_boost_pull = 1'b1;
      end
      if (idle_state && !idle_f.clean) begin
         next_idle_state = 1'b0;
      end

      if (s_cstop) begin
         next_burst = 1'b1;
      end
      if (burst && s_crest) begin
         next_burst = 1'b0;
      end

      case (phase)
         pss_pkg::PSS_OFF: begin
            if (s_lstart) begin
               next_phase = pss_pkg::PSS_CHARGE;
            end
         end
         pss_pkg::PSS_CHARGE: begin
            if (s_von) begin
               next_phase    = pss_pkg::PSS_PAUSE;
               next_hv_run   = 1'b1;
               next_tout_cnt = 32'h00000000;
               next_ss_cnt   = 32'h00000000;
            end
         end
         pss_pkg::PSS_ON_TIME: begin
            next_on_cnt = on_cnt + 32'h00000001;
            // end on-time at reference; or at peak limit, also while the limit ramps
            if (s_ref || s_ocp || on_cnt >= pss_pkg::TARGET_PERIOD_CYC - 1) begin
               next_phase   = pss_pkg::PSS_OFF_TIME;
               next_off_cnt = 32'h00000000;
               next_off_limit = (on_cnt + 32'h00000001 >= pss_pkg::TARGET_PERIOD_CYC) ? 32'h00000001
                                : pss_pkg::TARGET_PERIOD_CYC - (on_cnt + 32'h00000001);
            end
         end
         pss_pkg::PSS_OFF_TIME: begin
            next_off_cnt = off_cnt + 32'h00000001;
            if (burst || idle_state) begin
               next_phase = pss_pkg::PSS_PAUSE;
            end else if (off_cnt + 32'h00000001 >= off_limit) begin
               next_phase  = pss_pkg::PSS_ON_TIME;
               next_on_cnt = 32'h00000000;
            end
         end
         pss_pkg::PSS_PAUSE: begin
            if (!burst && !idle_state && !next_burst) begin
               next_phase  = pss_pkg::PSS_ON_TIME;
               next_on_cnt = 32'h00000000;
            end
         end
         default: next_phase = pss_pkg::PSS_OFF;
      endcase

      // shutdown at turn-off, recharge and restart; clear modes
      if (running && s_voff) begin
         next_phase      = pss_pkg::PSS_CHARGE;
         next_burst      = 1'b0;
         next_idle_state = 1'b0;
         next_boost_pull = 1'b0;
         next_hv_run     = 1'b0;
         next_recharge   = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase      <= pss_pkg::PSS_OFF;
         on_cnt     <= 32'h00000000;
         off_cnt    <= 32'h00000000;
         off_limit  <= 32'h00000001;
         tout_cnt   <= 32'h00000000;
         loss_cnt   <= 32'h00000000;
         ss_cnt     <= 32'h00000000;
         burst      <= 1'b0;
         idle_state <= 1'b0;
         boost_pull <= 1'b0;
         hv_run     <= 1'b0;
         recharge   <= 1'b0;
         disch      <= 1'b0;
      end else begin
         phase      <= next_phase;
         on_cnt     <= next_on_cnt;
         off_cnt    <= next_off_cnt;
         off_limit  <= next_off_limit;
         tout_cnt   <= next_tout_cnt;
         loss_cnt   <= next_loss_cnt;
         ss_cnt     <= next_ss_cnt;
         burst      <= next_burst;
         idle_state <= next_idle_state;
         boost_pull <= next_boost_pull;
         hv_run     <= next_hv_run;
         recharge   <= next_recharge;
         disch      <= next_disch;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   logic [39:0] ramp_prod;
   assign ramp_prod = 40'(ss_cnt) * 40'(pss_pkg::RAMP_FULL);
   assign gate_drive_out = (phase == pss_pkg::PSS_ON_TIME);
   // source on in charge phase, plus hold and recharge
   assign startup_source_on = (phase == pss_pkg::PSS_CHARGE && s_lstart) || hv_run || recharge;
   // reduced current into a shorted supply
   assign startup_source_reduced = startup_source_on && !s_vshort;
   assign discharge_on = disch;
   assign peak_limit_level = !running ? 8'h00 : ss_done ? pss_pkg::RAMP_FULL
                             : 8'(ramp_prod / 40'(SOFT_START_CYC));
   assign external_idle_mode = idle_state;
   assign error_amp_on = running && !idle_state;
   assign comp_high_z = idle_state;
   assign feedback_pullup_weak = idle_state && !boost_pull;
   assign feedback_pullup_strong = boost_pull;
   assign low_power = burst || idle_state || !running;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   gate_ends_ref_a: assert property (@(posedge clock) disable iff (!rst_n)
      (gate_drive_out && s_ref) |=> !gate_drive_out)
      else $error("gate stayed high after reference reached");
   off_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
      (phase == pss_pkg::PSS_OFF_TIME && off_cnt + 32'h00000001 >= off_limit && !burst && !idle_state
       && !s_voff) |=> gate_drive_out)
      else $error("gate did not return at off limit");
   period_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(gate_drive_out) && phase == pss_pkg::PSS_OFF_TIME && $past(on_cnt) < pss_pkg::TARGET_PERIOD_CYC - 1 |->
      off_limit + $past(on_cnt) + 32'h00000001 == pss_pkg::TARGET_PERIOD_CYC)
      else $error("off limit not period minus on-time");
   start_level_a: assert property (@(posedge clock) disable iff (!rst_n)
      (phase == pss_pkg::PSS_CHARGE && !s_von) |=> !gate_drive_out)
      else $error("switching before turn-on level");
   timeout_off_a: assert property (@(posedge clock) disable iff (!rst_n)
      (tout_cnt >= STARTUP_TIMEOUT_CYC) |-> !hv_run)
      else $error("startup source past timeout");
   discharge_go_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!disch && s_lloss && loss_cnt == LINE_LOSS_CYC - 1) |=> disch)
      else $error("discharge not started after detect time");
   burst_finish_a: assert property (@(posedge clock) disable iff (!rst_n)
      (gate_drive_out && burst && !s_ref && !s_ocp && on_cnt < pss_pkg::TARGET_PERIOD_CYC - 2
       && !s_voff) |=> gate_drive_out)
      else $error("on-time cut by burst");
   shutdown_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      (running && s_voff) |=> (phase == pss_pkg::PSS_CHARGE && !burst && !idle_state))
      else $error("shutdown did not clear modes");
endmodule : pss_sequencer

// >>> pss_stage_model.sv
// Boost stage model: current comparators follow the gate on-time
`timescale 1ns/100ps
module pss_stage_model (
   input  wire logic        clock,
   input  wire logic        gate_drive_out,
   input  wire logic [15:0] on_len,
   input  wire logic [15:0] peak_len,
   output logic             current_ref_reached,
   output logic             peak_limit_comparator
);
   logic [15:0] on_cnt;
   // Current ramps only while the switch conducts, so both flags drop one clock after the gate falls
   always_ff @(posedge clock) begin
      on_cnt                <= gate_drive_out ? on_cnt + 16'h0001 : 16'h0000;
      current_ref_reached   <= gate_drive_out && (on_cnt + 16'h0001 >= on_len);
      peak_limit_comparator <= gate_drive_out && (on_cnt + 16'h0001 >= peak_len);
   end
endmodule : pss_stage_model

// >>> tb_top.sv
// Self-checking bench for the switch sequencer
`timescale 1ns/100ps
module tb_top;
   localparam int unsigned TOUT_CYC = 50;
   localparam int unsigned LOSS_CYC = 40;
   localparam int unsigned SS_CYC   = 64;
   logic        clock, rst_n, current_ref_reached, peak_limit_comparator, line_above_start;
   logic        line_above_safe, line_loss_detected, supply_above_short, supply_at_turn_on;
   logic        supply_at_turn_off, supply_near_turn_off, feedback_above_release, feedback_below_idle;
   logic        feedback_above_idle_exit, feedback_at_reference, comp_below_burst_stop;
   logic        comp_above_burst_restart, gate_drive_out, startup_source_on, startup_source_reduced;
   logic        discharge_on, external_idle_mode, error_amp_on, comp_high_z;
   logic        feedback_pullup_weak, feedback_pullup_strong, low_power;
   logic [7:0]  peak_limit_level;
   logic [15:0] on_len, peak_len;
   logic [31:0] seed;
   logic        pend = 1'b0;
   int          fail_count = 0;
   int          comparisons = 0;
   int          rises = 0;
   int          n, n_note;
   longint      t_rise = 0;
   int          notes[$];

   pss_sequencer #(.STARTUP_TIMEOUT_CYC(TOUT_CYC), .LINE_LOSS_CYC(LOSS_CYC), .SOFT_START_CYC(SS_CYC))
      i_pss_sequencer (.clock, .rst_n, .current_ref_reached, .peak_limit_comparator, .line_above_start,
      .line_above_safe, .line_loss_detected, .supply_above_short, .supply_at_turn_on, .supply_at_turn_off,
      .supply_near_turn_off, .feedback_above_release, .feedback_below_idle, .feedback_above_idle_exit,
      .feedback_at_reference, .comp_below_burst_stop, .comp_above_burst_restart, .gate_drive_out,
      .startup_source_on, .startup_source_reduced, .discharge_on, .peak_limit_level, .external_idle_mode,
      .error_amp_on, .comp_high_z, .feedback_pullup_weak, .feedback_pullup_strong, .low_power);
   pss_stage_model i_pss_stage_model (.clock, .gate_drive_out, .on_len, .peak_len, .current_ref_reached,
      .peak_limit_comparator);

   // ----------------------------------------
   // Clock and helpers
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic step(input int c);
      repeat (c) @(posedge clock);
      #2;
   endtask : step
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic wait_gate(input logic v, input int bound);
      int k;
      k = 0;
      while (gate_drive_out !== v) begin
         if (k == bound) begin
            fail_count++;
            $display("CHECK FAILED at %0t: gate wait ran out", $time);
            give_verdict();
         end
         k++;
         step(1);
      end
   endtask : wait_gate
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   // On length is changed only in the off-time so the next pulse sees one value
   task automatic one_cycle(input int len, input int exp_on, input int per);
      wait_gate(1'b0, 400);
      on_len = 16'(len);
      notes.push_back(exp_on * 2 + per);
      wait_gate(1'b1, 400);
      wait_gate(1'b0, 400);
   endtask : one_cycle

   // ----------------------------------------
   // Output watcher
   // ----------------------------------------
   always @(posedge gate_drive_out) begin
      rises++;
      if (pend) chk(16'(($time - t_rise) / 40), 16'(pss_pkg::TARGET_PERIOD_CYC), "period"); // period
      pend = 1'b0;
      t_rise = $time;
   end
   always @(negedge gate_drive_out) begin
      if (notes.size() > 0) begin
         n_note = notes.pop_front();
         chk(16'(($time - t_rise) / 40), 16'(n_note / 2), "on-time"); // on-time end
         pend = (n_note % 2) == 1;
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      seed = 32'h00000043;
      {line_above_start, line_above_safe, line_loss_detected, supply_above_short, supply_at_turn_on,
         supply_at_turn_off, supply_near_turn_off, feedback_above_release, feedback_below_idle} = 9'h000;
      {feedback_above_idle_exit, feedback_at_reference, comp_below_burst_stop, comp_above_burst_restart} = 4'hD;
      on_len = 16'h0032;
      peak_len = 16'h03E8;
      step(12);
      rst_n = 1'b1;
      step(2);
      chk(16'({gate_drive_out, low_power, error_amp_on, startup_source_on, discharge_on}), 16'h0008, "reset");
      $display("test reset done");
      line_above_start = 1'b1;
      step(4);
      chk(16'({startup_source_on, startup_source_reduced}), 16'h0003, "reduced source");
      supply_above_short = 1'b1;
      step(4);
      chk(16'({startup_source_on, startup_source_reduced, gate_drive_out}), 16'h0004, "full source");
      chk(16'(peak_limit_level), 16'h0000, "limit idle");
      supply_at_turn_on = 1'b1;
      wait_gate(1'b1, 50);
      step(10);
      chk(16'(startup_source_on), 16'h0001, "source held");
      chk(16'(peak_limit_level != 8'h00 && peak_limit_level != pss_pkg::RAMP_FULL), 16'h0001, "ramp");
      step(60);
      chk(16'(startup_source_on), 16'h0000, "source timeout");
      chk(16'(peak_limit_level), 16'(pss_pkg::RAMP_FULL), "ramp end");
      $display("test startup done");
      for (int i = 0; i < 6; i++) begin
         n = 10 + int'(xs() % 291);
         one_cycle(n, n + 3, 1);
      end
      peak_len = 16'h0014;
      one_cycle(200, 23, 1);
      wait_gate(1'b1, 400);
      peak_len = 16'h03E8;
      $display("test switching done");
      line_above_safe = 1'b1;
      line_loss_detected = 1'b1;
      step(20);
      line_loss_detected = 1'b0;
      step(2);
      line_loss_detected = 1'b1;
      step(30);
      chk(16'(discharge_on), 16'h0000, "discharge early");
      step(20);
      chk(16'(discharge_on), 16'h0001, "discharge on");
      line_above_safe = 1'b0;
      step(4);
      chk(16'(discharge_on), 16'h0000, "discharge off");
      line_loss_detected = 1'b0;
      $display("test line loss done");
      wait_gate(1'b0, 400);
      on_len = 16'h0064;
      notes.push_back(103 * 2);
      wait_gate(1'b1, 400);
      step(5);
      {comp_below_burst_stop, comp_above_burst_restart} = 2'h2;
      wait_gate(1'b0, 200);
      n = rises;
      step(400);
      chk(16'({rises == n, low_power}), 16'h0003, "burst halt");
      {comp_below_burst_stop, comp_above_burst_restart} = 2'h1;
      wait_gate(1'b1, 20);
      $display("test burst done");
      {feedback_below_idle, feedback_above_idle_exit} = 2'h2;
      step(20);
      {feedback_below_idle, feedback_above_idle_exit} = 2'h1;
      step(60);
      chk(16'(external_idle_mode), 16'h0000, "idle glitch");
      {feedback_below_idle, feedback_above_idle_exit, feedback_at_reference} = 3'h4;
      step(60);
      chk(16'({external_idle_mode, error_amp_on, comp_high_z, feedback_pullup_weak, low_power}), 16'h0017,
         "idle entry");
      n = rises;
      step(400);
      chk(16'({rises == n, startup_source_on}), 16'h0002, "idle halt");
      {supply_at_turn_on, supply_near_turn_off} = 2'h1;
      step(4);
      chk(16'(startup_source_on), 16'h0001, "idle recharge");
      supply_near_turn_off = 1'b0;
      step(4);
      chk(16'(startup_source_on), 16'h0001, "recharge held");
      supply_at_turn_on = 1'b1;
      step(4);
      chk(16'(startup_source_on), 16'h0000, "recharge end");
      {feedback_below_idle, feedback_above_idle_exit} = 2'h1;
      step(10);
      chk(16'(feedback_pullup_strong), 16'h0001, "strong pull-up");
      step(50);
      chk(16'({external_idle_mode, peak_limit_level}), 16'(pss_pkg::RAMP_FULL), "idle exit");
      wait_gate(1'b1, 400);
      feedback_at_reference = 1'b1;
      step(4);
      chk(16'(feedback_pullup_strong), 16'h0000, "pull-up end");
      $display("test idle done");
      {supply_at_turn_on, supply_at_turn_off} = 2'h1;
      step(4);
      chk(16'({gate_drive_out, startup_source_on, low_power, peak_limit_level}), 16'h0300, "shutdown");
      supply_at_turn_off = 1'b0;
      step(10);
      chk(16'(gate_drive_out), 16'h0000, "await turn-on");
      supply_at_turn_on = 1'b1;
      wait_gate(1'b1, 50);
      step(5);
      chk(16'({startup_source_on, peak_limit_level != pss_pkg::RAMP_FULL}), 16'h0003, "restart");
      feedback_above_release = 1'b1;
      step(4);
      chk(16'(startup_source_on), 16'h0000, "source release");
      $display("test restart done");
      give_verdict();
   end
endmodule : tb_top
